// file: verilog/dcpp_pkg.sv
// shared constants, register map and types of the down-counter pwm timer
package dcpp_pkg;

   // ------------------------------------------------------------------
   // bus widths
   // ------------------------------------------------------------------
   localparam int DCPP_AW = 4;
   localparam int DCPP_DW = 8;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [DCPP_AW-1:0] DCPP_OFF_COUNT = 4'h0;
   localparam logic [DCPP_AW-1:0] DCPP_OFF_CTRL_A = 4'h1;
   localparam logic [DCPP_AW-1:0] DCPP_OFF_CTRL_B = 4'h2;
   localparam logic [DCPP_AW-1:0] DCPP_OFF_DUTY = 4'h3;
   localparam logic [DCPP_AW-1:0] DCPP_OFF_STATUS = 4'h4;
   localparam logic [DCPP_AW-1:0] DCPP_OFF_MASK = 4'h5;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int DCPP_A_EN = 0;
   localparam int DCPP_A_RL = 1;
   localparam int DCPP_A_OS = 2;
   localparam int DCPP_A_POL = 6;
   localparam int DCPP_A_PEN = 7;
   localparam int DCPP_B_RATE_LSB = 0;
   localparam int DCPP_B_RATE_MSB = 2;
   localparam int DCPP_B_PSD = 3;
   localparam int DCPP_B_EDGE = 4;
   localparam int DCPP_B_SRC = 5;
   localparam int DCPP_ST_UF = 0;
   localparam int DCPP_RATE_W = 3;

   // ------------------------------------------------------------------
   // reset values and read masks
   // ------------------------------------------------------------------
   localparam logic [DCPP_DW-1:0] DCPP_CTRL_A_RST = 8'h00;
   localparam logic [DCPP_DW-1:0] DCPP_CTRL_B_RST = 8'h3f;
   localparam logic [DCPP_DW-1:0] DCPP_COUNT_RST = 8'hff;
   localparam logic [DCPP_DW-1:0] DCPP_DUTY_RST = 8'h00;
   localparam logic [DCPP_DW-1:0] DCPP_ZERO = 8'h00;
   localparam logic [DCPP_DW-1:0] DCPP_ALL_ONES = 8'hff;
   localparam logic [DCPP_DW-1:0] DCPP_CTRL_A_RD = 8'h07;
   localparam logic [DCPP_DW-1:0] DCPP_CTRL_B_RD = 8'h3f;
   localparam logic [DCPP_DW-1:0] DCPP_EVT_RD = 8'h01;

   // ------------------------------------------------------------------
   // counter states, gray along idle -> run -> done
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      DCPP_IDLE = 2'b00,
      DCPP_RUN = 2'b01,
      DCPP_DONE = 2'b11
   } dcpp_state_t;

   function automatic logic dcpp_hit(input logic [DCPP_AW-1:0] addr,
                                     input logic [DCPP_AW-1:0] off);
      return addr == off;
   endfunction : dcpp_hit

endpackage : dcpp_pkg

// file: verilog/dcpp_edge_sync.sv
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module dcpp_edge_sync (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic pin_in,
   output logic rise,
   output logic fall
);

   // ------------------------------------------------------------------
   // synchroniser; meta_q is read by sync_q only
   // ------------------------------------------------------------------
   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;

endmodule : dcpp_edge_sync

// file: verilog/dcpp_prescaler.sv
// power-of-two prescaler with bypass
`timescale 1ns/1ps
module dcpp_prescaler
   import dcpp_pkg::*;
#(
   parameter int PW = 8
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic src_tick,
   input wire logic bypass,
   input wire logic [DCPP_RATE_W-1:0] rate,
   output logic out_tick
);

   // ------------------------------------------------------------------
   // ripple count and all-ones taps
   // ------------------------------------------------------------------
   logic [PW-1:0] cnt_q;
   logic [PW-1:0] tap;

   generate
      for (genvar i = 0; i < PW; i++) begin : g_tap
         assign tap[i] = &cnt_q[i:0];
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
      end else if (src_tick) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // rate n divides by 2^(n+1): tick when the low n+1 bits wrap
   assign out_tick = src_tick & (bypass | tap[rate]); // [R9] [R10]

endmodule : dcpp_prescaler

// file: verilog/dcpp_top.sv
// down-counting timer with reload, one-shot, prescaler and pwm pin output
`timescale 1ns/1ps

// What this block does
// R1 - reading the count register returns the live 8-bit count
// R2 - writing the count register sets reload value and running count together
// R3 - non-stop, reload-select clear: underflow loads all ones, counting continues
// R4 - non-stop, reload-select set: underflow loads the stored reload value
// R5 - one-shot: count once down to zero, stop at underflow
// R6 - reload-select only matters in non-stop mode
// R7 - polarity bit one makes pwm active low, zero active high
// R8 - pin enable drives pwm on the port pin, else pin is plain gpio
// R9 - rate field divides count clock by 2 (000) up to 256 (111)
// R10 - prescale_disable_n high bypasses prescaler, low inserts it
// R11 - source bit one picks external pin, zero the instruction clock
// R12 - edge bit one counts on falling external edges, zero on rising
// R13 - pwm inactive after enable, active from count equal duty until underflow
// R14 - counter decrements per prescaled tick only while enabled, else holds
// R15 - every underflow sets a sticky flag only software clears
module dcpp_top
   import dcpp_pkg::*;
#(
   parameter int CW = DCPP_DW,
   parameter int PRESCALE_W = 8
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [DCPP_AW-1:0] reg_addr,
   input wire logic [DCPP_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DCPP_DW-1:0] reg_rdata,
   input wire logic external_count_pin,
   input wire logic gpio_out,
   input wire logic gpio_oe_n,
   output logic pwm_port_pin_o,
   output logic pwm_port_pin_oe_n,
   output logic irq
);

   // ------------------------------------------------------------------
   // register bus decode
   // ------------------------------------------------------------------
   logic wr_count;
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_duty;
   logic wr_status;
   logic wr_mask;

   assign wr_count = reg_wr & dcpp_hit(reg_addr, DCPP_OFF_COUNT);
   assign wr_ctrl_a = reg_wr & dcpp_hit(reg_addr, DCPP_OFF_CTRL_A);
   assign wr_ctrl_b = reg_wr & dcpp_hit(reg_addr, DCPP_OFF_CTRL_B);
   assign wr_duty = reg_wr & dcpp_hit(reg_addr, DCPP_OFF_DUTY);
   assign wr_status = reg_wr & dcpp_hit(reg_addr, DCPP_OFF_STATUS);
   assign wr_mask = reg_wr & dcpp_hit(reg_addr, DCPP_OFF_MASK);

   // ------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------
   logic [DCPP_DW-1:0] ctrl_a_q;
   logic [DCPP_DW-1:0] ctrl_b_q;
   logic [DCPP_DW-1:0] duty_q;
   logic [DCPP_DW-1:0] mask_q;
   logic [CW-1:0] reload_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic [DCPP_DW-1:0] status_q;
   logic [DCPP_DW-1:0] status_d;
   logic [DCPP_DW-1:0] rdata_q;
   logic [DCPP_DW-1:0] rdata_d;
   dcpp_state_t state_q;
   dcpp_state_t state_d;
   logic pwm_act_q;
   logic pwm_act_d;
   logic pin_q;
   logic pin_oe_n_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_a_q <= DCPP_CTRL_A_RST;
         ctrl_b_q <= DCPP_CTRL_B_RST;
         duty_q <= DCPP_DUTY_RST;
         mask_q <= DCPP_ZERO;
      end else begin
         if (wr_ctrl_a) begin
            ctrl_a_q <= reg_wdata;
         end
         if (wr_ctrl_b) begin
            ctrl_b_q <= reg_wdata & DCPP_CTRL_B_RD;
         end
         if (wr_duty) begin
            duty_q <= reg_wdata;
         end
         if (wr_mask) begin
            mask_q <= reg_wdata & DCPP_EVT_RD;
         end
      end
   end

   // ------------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------------
   logic enable;
   logic reload_sel;
   logic one_shot;
   logic pwm_pol;
   logic pwm_pin_en;
   logic ext_src;
   logic ext_fall;
   logic presc_dis_n;
   logic [DCPP_RATE_W-1:0] presc_rate;

   assign enable = ctrl_a_q[DCPP_A_EN];
   assign reload_sel = ctrl_a_q[DCPP_A_RL];
   assign one_shot = ctrl_a_q[DCPP_A_OS];
   assign pwm_pol = ctrl_a_q[DCPP_A_POL];
   assign pwm_pin_en = ctrl_a_q[DCPP_A_PEN];
   assign ext_src = ctrl_b_q[DCPP_B_SRC];
   assign ext_fall = ctrl_b_q[DCPP_B_EDGE];
   assign presc_dis_n = ctrl_b_q[DCPP_B_PSD];
   assign presc_rate = ctrl_b_q[DCPP_B_RATE_MSB:DCPP_B_RATE_LSB];

   // ------------------------------------------------------------------
   // count source and prescaler
   // ------------------------------------------------------------------
   logic ext_rise_p;
   logic ext_fall_p;
   logic src_tick;
   logic cnt_tick;

   // external pin is sampled, so it must stay below half of clk_sys
   dcpp_edge_sync u_ext_sync (
      .clk_sys (clk_sys),
      .rstn (rstn),
      .pin_in (external_count_pin),
      .rise (ext_rise_p),
      .fall (ext_fall_p)
   );

   // instruction clock is clk_sys itself, one source tick per cycle
   assign src_tick = ext_src ? (ext_fall ? ext_fall_p : ext_rise_p) : 1'b1; // [R11] [R12]

   dcpp_prescaler #(
      .PW (PRESCALE_W)
   ) u_presc (
      .clk_sys (clk_sys),
      .rstn (rstn),
      .src_tick (src_tick),
      .bypass (presc_dis_n),
      .rate (presc_rate),
      .out_tick (cnt_tick)
   );

   // ------------------------------------------------------------------
   // down-counter
   // ------------------------------------------------------------------
   logic running;
   logic step;
   logic at_zero;
   logic underflow;
   logic [CW-1:0] reload_val;

   assign running = (state_q == DCPP_RUN);
   assign step = cnt_tick & running & ~wr_count; // [R14]
   assign at_zero = (count_q == CW'(DCPP_ZERO));
   assign underflow = step & at_zero;
   // reload select is ignored while one-shot is set
   assign reload_val = (reload_sel & ~one_shot) ? reload_q : CW'(DCPP_ALL_ONES); // [R3] [R4] [R6]

   always_comb begin
      count_d = count_q;
      if (wr_count) begin
         count_d = CW'(reg_wdata); // [R2]
      end else if (underflow) begin
         count_d = one_shot ? count_q : reload_val; // [R3] [R4] [R5]
      end else if (step) begin
         count_d = count_q - 1'b1; // [R14]
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         DCPP_IDLE: begin
            if (enable) begin
               state_d = DCPP_RUN;
            end
         end
         DCPP_RUN: begin
            if (!enable) begin
               state_d = DCPP_IDLE; // [R14]
            end else if (underflow && one_shot) begin
               state_d = DCPP_DONE; // [R5]
            end
         end
         DCPP_DONE: begin
            // a count write rearms a finished one-shot
            if (!enable) begin
               state_d = DCPP_IDLE;
            end else if (wr_count) begin
               state_d = DCPP_RUN;
            end
         end
         default: begin
            state_d = DCPP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         count_q <= CW'(DCPP_COUNT_RST);
         reload_q <= CW'(DCPP_COUNT_RST);
         state_q <= DCPP_IDLE;
      end else begin
         count_q <= count_d;
         state_q <= state_d;
         if (wr_count) begin
            reload_q <= CW'(reg_wdata); // [R2]
         end
      end
   end

   // ------------------------------------------------------------------
   // pwm output and pin routing
   // ------------------------------------------------------------------
   logic duty_match;
   logic pwm_level;

   assign duty_match = (count_q == CW'(duty_q));

   always_comb begin
      pwm_act_d = pwm_act_q;
      if (!running || underflow) begin
         pwm_act_d = 1'b0; // [R13]
      end else if (duty_match) begin
         pwm_act_d = 1'b1; // [R13]
      end
   end

   assign pwm_level = pwm_act_q ^ pwm_pol; // [R7]

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pwm_act_q <= 1'b0;
         pin_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end else begin
         pwm_act_q <= pwm_act_d;
         pin_q <= pwm_pin_en ? pwm_level : gpio_out; // [R8]
         pin_oe_n_q <= pwm_pin_en ? 1'b0 : gpio_oe_n; // [R8]
      end
   end

   assign pwm_port_pin_o = pin_q;
   assign pwm_port_pin_oe_n = pin_oe_n_q;

   // ------------------------------------------------------------------
   // event status and interrupt
   // ------------------------------------------------------------------
   logic [DCPP_DW-1:0] status_clr;
   logic [DCPP_DW-1:0] status_set;

   assign status_clr = wr_status ? (reg_wdata & DCPP_EVT_RD) : DCPP_ZERO;
   assign status_set = {{(DCPP_DW-1){1'b0}}, underflow};
   // a set in the clearing cycle wins
   assign status_d = (status_q & ~status_clr) | status_set; // [R15]

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         status_q <= DCPP_ZERO;
      end else begin
         status_q <= status_d;
      end
   end

   assign irq = |(status_q & mask_q);

   // ------------------------------------------------------------------
   // read path, data valid only in the cycle after the strobe
   // ------------------------------------------------------------------
   logic [DCPP_DW-1:0] rd_mux;

   assign rd_mux =
      dcpp_hit(reg_addr, DCPP_OFF_COUNT) ? DCPP_DW'(count_q) : // [R1]
      dcpp_hit(reg_addr, DCPP_OFF_CTRL_A) ? (ctrl_a_q & DCPP_CTRL_A_RD) :
      dcpp_hit(reg_addr, DCPP_OFF_CTRL_B) ? ctrl_b_q :
      dcpp_hit(reg_addr, DCPP_OFF_STATUS) ? status_q :
      dcpp_hit(reg_addr, DCPP_OFF_MASK) ? mask_q :
      DCPP_ZERO;

   assign rdata_d = reg_rd ? rd_mux : DCPP_ZERO;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= DCPP_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : dcpp_top

// file: verif/dcpp_chk.sv
// port checker of the down-counter pwm timer
`timescale 1ns/1ps
module dcpp_chk
   import dcpp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [DCPP_AW-1:0] reg_addr,
   input wire logic [DCPP_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DCPP_DW-1:0] reg_rdata,
   input wire logic external_count_pin,
   input wire logic gpio_out,
   input wire logic gpio_oe_n,
   input wire logic pwm_port_pin_o,
   input wire logic pwm_port_pin_oe_n,
   input wire logic irq
);
   // ---------------------------------------------
   // shadows of write-only pin controls and of the readable enable bit
   // ---------------------------------------------
   logic pen_q;
   logic pol_q;
   logic en_q;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pen_q <= 1'b0;
         pol_q <= 1'b0;
         en_q <= 1'b0;
      end else if (reg_wr && reg_addr == DCPP_OFF_CTRL_A) begin
         pen_q <= reg_wdata[DCPP_A_PEN];
         pol_q <= reg_wdata[DCPP_A_POL];
         en_q <= reg_wdata[DCPP_A_EN];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_wr_cnt;
      reg_wr && reg_addr == DCPP_OFF_COUNT;
   endsequence
   sequence s_rd_cnt;
      reg_rd && reg_addr == DCPP_OFF_COUNT;
   endsequence
   sequence s_wr_rd_a;
      reg_wr && reg_addr == DCPP_OFF_CTRL_A ##1 reg_rd && reg_addr == DCPP_OFF_CTRL_A;
   endsequence
   // three quiet cycles let the active flag and pin flop settle
   sequence s_quiet_lo;
      (pen_q && !en_q && pol_q)[*3];
   endsequence
   sequence s_quiet_hi;
      (pen_q && !en_q && !pol_q)[*3];
   endsequence
   property p_wr_rd;
      s_wr_cnt ##1 s_rd_cnt |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   property p_rd_idle;
      !reg_rd |=> reg_rdata == DCPP_ZERO;
   endproperty
   property p_unmap;
      reg_rd && reg_addr > DCPP_OFF_MASK |=> reg_rdata == DCPP_ZERO;
   endproperty
   property p_ctrl_a;
      s_wr_rd_a |=> reg_rdata == ($past(reg_wdata, 2) & DCPP_CTRL_A_RD);
   endproperty
   property p_irq_mask;
      reg_wr && reg_addr == DCPP_OFF_MASK && !reg_wdata[0] |=> !irq;
   endproperty
   property p_gpio;
      !pen_q |=> pwm_port_pin_o == $past(gpio_out) && pwm_port_pin_oe_n == $past(gpio_oe_n);
   endproperty
   property p_route;
      pen_q |=> !pwm_port_pin_oe_n;
   endproperty
   property p_idle_lo;
      s_quiet_lo |=> pwm_port_pin_o;
   endproperty
   property p_idle_hi;
      s_quiet_hi |=> !pwm_port_pin_o;
   endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("count write not read back");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_ctrl_a: assert property (p_ctrl_a) else $error("control readback wrong");
   a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
   a_gpio: assert property (p_gpio) else $error("pin not following port");
   a_route: assert property (p_route) else $error("pin not driven");
   a_idle_lo: assert property (p_idle_lo) else $error("inactive level wrong");
   a_idle_hi: assert property (p_idle_hi) else $error("inactive level wrong");
endmodule : dcpp_chk

bind dcpp_top dcpp_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .external_count_pin(external_count_pin), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
   .pwm_port_pin_o(pwm_port_pin_o), .pwm_port_pin_oe_n(pwm_port_pin_oe_n), .irq(irq));

// file: verif/dcpp_top_tb_top.sv
// self-checking bench of the down-counter pwm timer
`timescale 1ns/1ps
module down_counter_pwm_prescaler_tb_top
   import dcpp_pkg::*;
();
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [DCPP_AW-1:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic external_count_pin = 1'b0;
   logic gpio_out = 1'b0;
   logic gpio_oe_n = 1'b1;
   logic [7:0] reg_rdata;
   logic pwm_port_pin_o;
   logic pwm_port_pin_oe_n;
   logic irq;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   logic rd_seen = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] n;
   logic [7:0] e;
   logic [31:0] g;
   int h4;
   int h6;
   int hl;
   logic [7:0] rv[7] = '{DCPP_COUNT_RST, DCPP_CTRL_A_RST, DCPP_CTRL_B_RST, DCPP_ZERO,
      DCPP_ZERO, DCPP_ZERO, DCPP_ZERO};

   dcpp_top dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_count_pin(external_count_pin), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .pwm_port_pin_o(pwm_port_pin_o), .pwm_port_pin_oe_n(pwm_port_pin_oe_n), .irq(irq));

   always #20 clk_sys = ~clk_sys;

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task finish_test;
      if (error_cnt == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : rd

   task wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] x);
      wr(a, d);
      reg_rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : wr_rd

   // decrements seen = k + 2 with the internal, bypassed source
   task run(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input int k);
      wr(DCPP_OFF_CTRL_B, b);
      wr(DCPP_OFF_COUNT, c);
      wr(DCPP_OFF_CTRL_A, a | 8'h01);
      repeat (k) @(posedge clk_sys);
      wr(DCPP_OFF_CTRL_A, a & 8'hfe);
   endtask : run

   function automatic logic [7:0] step(input logic [7:0] c, input logic rl, input logic os,
                                       input logic [7:0] r);
      if (c != 8'h00)
         return c - 8'h01;
      if (os)
         return 8'h00;
      return rl ? r : 8'hff;
   endfunction : step

   // one reload period of 11 cycles, counted while the counter still runs
   task pwm(input logic [7:0] d, input logic pol, output int h);
      wr(DCPP_OFF_DUTY, d);
      wr(DCPP_OFF_CTRL_B, 8'h08);
      wr(DCPP_OFF_COUNT, 8'h0a);
      wr(DCPP_OFF_CTRL_A, {1'b1, pol, 6'h03});
      repeat (14) @(posedge clk_sys);
      h = 0;
      repeat (11) begin
         @(negedge clk_sys);
         if ((pwm_port_pin_o ^ pol) === 1'b1)
            h++;
      end
      check("pin_oe_n", {7'h00, pwm_port_pin_oe_n}, 8'h00);
      // stop but keep the pin routed, so the inactive level shows
      wr(DCPP_OFF_CTRL_A, {1'b1, pol, 6'h00});
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      check("pin_idle", {7'h00, pwm_port_pin_o}, {7'h00, pol});
      wr(DCPP_OFF_CTRL_A, 8'h00);
   endtask : pwm

   always @(posedge clk_sys) begin
      if (rd_seen)
         check("reg_rdata", reg_rdata, exp_q.pop_front());
      rd_seen = reg_rd;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   initial begin
      void'($urandom(32'hb2ac));
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd(4'(i), rv[i]);
      wr(4'hf, 8'h5a);
      rd(4'hf, 8'h00);
      n = 8'($urandom);
      wr_rd(DCPP_OFF_COUNT, n, n);
      wr_rd(DCPP_OFF_CTRL_A, 8'hc6, 8'h06);
      for (int m = 0; m < 4; m++) begin
         n = 8'h03 + 8'($urandom % 4);
         e = n;
         for (int i = 0; i < 10; i++)
            e = step(e, m[0], m[1], n);
         run({5'h00, m[1], m[0], 1'b0}, 8'h08, n, 8);
         rd(DCPP_OFF_COUNT, e);
         rd(DCPP_OFF_STATUS, 8'h01);
         wr(DCPP_OFF_STATUS, 8'h01);
         rd(DCPP_OFF_STATUS, 8'h00);
      end
      for (int r = 0; r < 8; r++) begin
         n = 8'h80 + 8'($urandom % 64);
         run(8'h00, 8'(r), n, (2 << r) - 2);
         rd(DCPP_OFF_COUNT, n - 8'h01);
      end
      for (int x = 0; x < 2; x++) begin
         external_count_pin <= 1'b1;
         n = 8'h40 + 8'($urandom % 64);
         wr(DCPP_OFF_CTRL_B, {3'b001, x[0], 4'h8});
         wr(DCPP_OFF_COUNT, n);
         wr(DCPP_OFF_CTRL_A, 8'h01);
         repeat (5) begin
            @(posedge clk_sys);
            external_count_pin <= 1'b0;
            repeat (3) @(posedge clk_sys);
            external_count_pin <= 1'b1;
            repeat (2) @(posedge clk_sys);
         end
         @(posedge clk_sys);
         external_count_pin <= 1'b0;
         repeat (8) @(posedge clk_sys);
         wr(DCPP_OFF_CTRL_A, 8'h00);
         rd(DCPP_OFF_COUNT, n - 8'h05 - 8'(x));
      end
      wr(DCPP_OFF_MASK, 8'h01);
      run(8'h00, 8'h08, 8'h01, 4);
      @(negedge clk_sys);
      check("irq", {7'h00, irq}, 8'h01);
      wr(DCPP_OFF_MASK, 8'h00);
      @(negedge clk_sys);
      check("irq", {7'h00, irq}, 8'h00);
      wr(DCPP_OFF_MASK, 8'h01);
      wr(DCPP_OFF_STATUS, 8'h01);
      @(negedge clk_sys);
      check("irq", {7'h00, irq}, 8'h00);
      pwm(8'h04, 1'b0, h4);
      pwm(8'h06, 1'b0, h6);
      pwm(8'h04, 1'b1, hl);
      check("duty_step", 8'(h6 - h4), 8'h02);
      check("duty_len", 8'(h4), 8'h04);
      check("polarity", 8'(hl), 8'h04);
      repeat (8) begin
         @(posedge clk_sys);
         g = $urandom;
         gpio_out <= g[0];
         gpio_oe_n <= g[1];
         @(posedge clk_sys);
         @(negedge clk_sys);
         check("pin_o", {7'h00, pwm_port_pin_o}, {7'h00, g[0]});
         check("pin_oe_n", {7'h00, pwm_port_pin_oe_n}, {7'h00, g[1]});
      end
      repeat (4) @(posedge clk_sys);
      finish_test();
   end
endmodule : down_counter_pwm_prescaler_tb_top
